// File: pkg/err_status_pkg.sv
// Purpose: Shared constants for the host error status register bank
// Assumes: Byte-wide register port driven by the serial interface engine
// Notes: Offsets are byte addresses on that port
package err_status_pkg;
  // ************************************************************
  // Register map
  // ************************************************************
  // Voltage channel 9 to 16 window flags
  localparam logic [7:0] ADDR_VOLT_FLAGS = 8'h4a;
  // Termination, core voltage and diode fault flags
  localparam logic [7:0] ADDR_FAULT_FLAGS = 8'h4b;
  // Value of both registers after reset
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  // Answer to a read of an unmapped offset
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // ************************************************************
  // Field positions of the fault register
  // ************************************************************
  localparam int TERM1_BIT = 2;
  localparam int TERM2_BIT = 3;
  localparam int CORE1_BIT = 4;
  localparam int CORE2_BIT = 5;
  localparam int DIODE1_BIT = 6;
  localparam int DIODE2_BIT = 7;
  // Lowest implemented bit; bits below read as zero
  localparam int FAULT_LOW_BIT = 2;
  // Implemented bits of the fault register
  localparam logic [7:0] FAULT_IMPL_MASK = 8'hfc;

  // ************************************************************
  // Channel numbering
  // ************************************************************
  // First monitored channel held in the voltage flag register
  localparam int FIRST_CHANNEL = 9;
  // Number of channels held there
  localparam int CHANNEL_COUNT = 8;
  // Cycles from a read strobe to its data
  localparam int READ_LATENCY = 1;
endpackage

// File: hw/sticky_flag.sv
// Purpose: One sticky error flag with write-one-to-clear
// Assumes: Set and clear are synchronous one-cycle or level requests
// Notes: A set in the clearing cycle wins so no event is lost
`timescale 1ns/1ps
module sticky_flag (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic set,
  input wire logic clear,
  output logic q
);
  // ************************************************************
  // Flag storage
  // ************************************************************
  // Set has priority over clear; the flag holds otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clear) begin
      q <= 1'b0;
    end
  end
endmodule

// File: hw/host_error_status_bank.sv
// Purpose: Sticky host error status registers for channels 9 to 16 and faults
// Assumes: Measurement engine gives samples, limits and mismatch results
// Notes: Register port is the byte port behind the serial interface
// Operation
// R1: Flag channel outside its low/high window
// R2: Flag termination fault inputs on bits 2, 3
// R3: Flag core voltage not matching requested VID
// R4: Flag first remote diode open or short
// R5: Flag second remote diode open or short
// R6: Flags sticky until written one; reset zero
`timescale 1ns/1ps
module host_error_status_bank #(
  parameter int CHANNELS = err_status_pkg::CHANNEL_COUNT,
  parameter int SAMPLE_W = 8
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Per-channel conversion results, channel 9 in the lowest slice
  input wire logic [CHANNELS*SAMPLE_W-1:0] CHAN_SAMPLE,
  input wire logic [CHANNELS-1:0] CHAN_SAMPLE_VALID,
  input wire logic [CHANNELS*SAMPLE_W-1:0] CHAN_LOW_LIMIT,
  input wire logic [CHANNELS*SAMPLE_W-1:0] CHAN_HIGH_LIMIT,
  // Termination fault inputs, high while asserted
  input wire logic TERMINATION_FAULT_INPUT_1,
  input wire logic TERMINATION_FAULT_INPUT_2,
  // Core voltage against VID comparison results
  input wire logic CORE1_VID_MISMATCH,
  input wire logic CORE2_VID_MISMATCH,
  // Remote diode open or short detections
  input wire logic REMOTE_SENSOR1_FAULT,
  input wire logic REMOTE_SENSOR2_FAULT,
  // Byte register port
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID
);
  // ************************************************************
  // Decode
  // ************************************************************
  // Address hits
  logic hit_volt;
  logic hit_fault;
  // Write-one clear requests per register
  logic [7:0] clr_volt;
  logic [7:0] clr_fault;
  // Set requests per register
  logic [CHANNELS-1:0] set_volt;
  logic [7:0] set_fault;
  // Stored flags
  logic [CHANNELS-1:0] chan_limit_flag;
  logic [7:0] fault_flags;
  // Read mux result
  logic [7:0] next_rdata;
  // Register views
  logic [7:0] volt_view;
  logic [7:0] fault_view;

  assign hit_volt = (REG_ADDR == err_status_pkg::ADDR_VOLT_FLAGS);
  assign hit_fault = (REG_ADDR == err_status_pkg::ADDR_FAULT_FLAGS);
  // Clear only on a write hitting the register, one data bit per flag
  // R6: write one clears
  assign clr_volt = (REG_WR && hit_volt) ? REG_WDATA : 8'h00;
  assign clr_fault = (REG_WR && hit_fault) ? REG_WDATA : 8'h00;

  // ************************************************************
  // Channel window flags
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi = gi + 1) begin : g_chan
      // Slices of this channel
      logic [SAMPLE_W-1:0] smp;
      logic [SAMPLE_W-1:0] lo;
      logic [SAMPLE_W-1:0] hi;
      assign smp = CHAN_SAMPLE[gi*SAMPLE_W +: SAMPLE_W];
      assign lo = CHAN_LOW_LIMIT[gi*SAMPLE_W +: SAMPLE_W];
      assign hi = CHAN_HIGH_LIMIT[gi*SAMPLE_W +: SAMPLE_W];
      // R1: outside window sets
      // Only a fresh conversion is judged, so a stale sample cannot re-flag
      assign set_volt[gi] = CHAN_SAMPLE_VALID[gi] && ((smp < lo) || (smp > hi));
      sticky_flag u_flag (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .set(set_volt[gi]),
        .clear(clr_volt[gi]),
        .q(chan_limit_flag[gi])
      );
      // R1: out-of-window sample flags
      a_chan_window_set: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R1
        set_volt[gi] |=> chan_limit_flag[gi])
        else $error("channel flag not set after out-of-window sample");
      // R6: flag holds without clear
      a_chan_flag_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R6
        (chan_limit_flag[gi] && !clr_volt[gi]) |=> chan_limit_flag[gi])
        else $error("channel flag dropped without a clear");
    end
  endgenerate

  // ************************************************************
  // Fault flags
  // ************************************************************
  // Gather fault sources at their bit positions; low bits never set
  always_comb begin
    set_fault = 8'h00;
    // R2: termination inputs set
    set_fault[err_status_pkg::TERM1_BIT] = TERMINATION_FAULT_INPUT_1;
    set_fault[err_status_pkg::TERM2_BIT] = TERMINATION_FAULT_INPUT_2;
    // R3: VID mismatch sets
    set_fault[err_status_pkg::CORE1_BIT] = CORE1_VID_MISMATCH;
    set_fault[err_status_pkg::CORE2_BIT] = CORE2_VID_MISMATCH;
    // R4: diode one fault
    set_fault[err_status_pkg::DIODE1_BIT] = REMOTE_SENSOR1_FAULT;
    // R5: diode two fault
    set_fault[err_status_pkg::DIODE2_BIT] = REMOTE_SENSOR2_FAULT;
  end

  generate
    for (gi = err_status_pkg::FAULT_LOW_BIT; gi < 8; gi = gi + 1) begin : g_fault
      sticky_flag u_flag (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .set(set_fault[gi]),
        .clear(clr_fault[gi]),
        .q(fault_flags[gi])
      );
    end
    for (gi = 0; gi < err_status_pkg::FAULT_LOW_BIT; gi = gi + 1) begin : g_rsvd
      // R6: reserved bits zero
      assign fault_flags[gi] = 1'b0;
    end
  endgenerate

  // ************************************************************
  // Read port
  // ************************************************************
  // Narrow channel counts pad with zeros in the upper bits
  always_comb begin
    volt_view = 8'h00;
    volt_view[CHANNELS-1:0] = chan_limit_flag;
    fault_view = fault_flags & err_status_pkg::FAULT_IMPL_MASK;
  end

  // Unmapped offsets answer zero rather than holding stale data
  always_comb begin
    if (hit_volt) begin
      next_rdata = volt_view;
    end else if (hit_fault) begin
      next_rdata = fault_view;
    end else begin
      next_rdata = err_status_pkg::UNMAPPED_DATA;
    end
  end

  // Read data is captured on the strobe and held until the next read
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= err_status_pkg::FLAGS_RESET;
    end else if (REG_RD) begin
      REG_RDATA <= next_rdata;
    end
  end

  // Valid marks the cycle after the strobe
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  // R2: termination one flags
  a_term1_flag_set: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R2
    TERMINATION_FAULT_INPUT_1 |=> fault_flags[err_status_pkg::TERM1_BIT])
    else $error("termination 1 flag not set");
  // R2: termination two flags
  a_term2_flag_set: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R2
    TERMINATION_FAULT_INPUT_2 |=> fault_flags[err_status_pkg::TERM2_BIT])
    else $error("termination 2 flag not set");
  // R3: core one mismatch
  // Each core is tied to its own bit, so a swapped wiring cannot slip through
  a_core_vid_set: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R3
    CORE1_VID_MISMATCH |=> fault_flags[err_status_pkg::CORE1_BIT])
    else $error("core 1 mismatch flag not set");
  // R3: core two mismatch
  a_core2_vid_set: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R3
    CORE2_VID_MISMATCH |=> fault_flags[err_status_pkg::CORE2_BIT])
    else $error("core 2 mismatch flag not set");
  // R4: diode one flags
  a_diode1_flag_set: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R4
    REMOTE_SENSOR1_FAULT |=> fault_flags[err_status_pkg::DIODE1_BIT])
    else $error("diode 1 flag not set");
  // R5: diode two flags
  a_diode2_flag_set: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R5
    REMOTE_SENSOR2_FAULT |=> fault_flags[err_status_pkg::DIODE2_BIT])
    else $error("diode 2 flag not set");
  // R6: clear takes effect
  a_fault_clear_works: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R6
    (REG_WR && hit_fault && REG_WDATA[err_status_pkg::TERM1_BIT] &&
     !TERMINATION_FAULT_INPUT_1) |=> !fault_flags[err_status_pkg::TERM1_BIT])
    else $error("termination 1 flag not cleared by write one");
  // R6: reserved reads zero
  a_rsvd_read_zero: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R6
    (REG_RD && hit_fault) |=> (REG_RVALID && REG_RDATA[1:0] == 2'b00 &&
    REG_RDATA[7:2] == $past(fault_flags[7:2])))
    else $error("fault register read data wrong");
endmodule

// File: dv/host_model.sv
// Purpose: Host side of the byte register port
// Assumes: Requests are launched on the falling edge of the clock
// Notes: Released address and data are inverted so no stale value lingers
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  // ************************************************************
  // Idle state and access tasks
  // ************************************************************
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = dat;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~dat;
  endtask
  // Data is taken in the cycle the valid pulse stands; no pulse gives unknown
  task automatic rd(input logic [7:0] a, output logic [7:0] dat);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    dat = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask
endmodule

// File: dv/host_error_status_bank_bench.sv
// Purpose: Self-checking bench for the host error status bank
// Assumes: Limits fixed at 0x40 and 0xc0 for every channel
// Notes: Fault inputs are pulsed one cycle, which is enough to set a flag, except one held high through a clear
`timescale 1ns/1ps
module host_error_status_bank_bench;
  logic clk = 1'b0; // System clock
  logic rst_n = 1'b0; // Active low reset
  logic [63:0] smp = '0; // Channel samples
  logic [63:0] lo = '0; // Low limits
  logic [63:0] hi = '0; // High limits
  logic [7:0] vld = 8'h00; // Sample valid per channel
  logic [5:0] flt = 6'h00; // Fault sources in register bit order
  logic [7:0] addr, wdata, rdata, d, acc;
  logic wr, rd, rvalid;
  int err_total = 0;
  int total_checks = 0;
  always #5 clk = ~clk;
  host_error_status_bank u_dut (.CLK_SYS(clk), .RST_N(rst_n), .CHAN_SAMPLE(smp),
    .CHAN_SAMPLE_VALID(vld), .CHAN_LOW_LIMIT(lo), .CHAN_HIGH_LIMIT(hi),
    .TERMINATION_FAULT_INPUT_1(flt[0]), .TERMINATION_FAULT_INPUT_2(flt[1]),
    .CORE1_VID_MISMATCH(flt[2]), .CORE2_VID_MISMATCH(flt[3]),
    .REMOTE_SENSOR1_FAULT(flt[4]), .REMOTE_SENSOR2_FAULT(flt[5]), .REG_ADDR(addr),
    .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid));
  host_model u_host (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
    .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rvalid));
  // ************************************************************
  // Helpers
  // ************************************************************
  task check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] exp);
    u_host.rd(a, d);
    check(d, exp);
  endtask
  // One-cycle valid pulse on the chosen channels
  task pulse_vld(input logic [7:0] m);
    @(negedge clk);
    vld = m;
    @(negedge clk);
    vld = 8'h00;
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    // Even channels below the window, odd ones above it
    for (int i = 0; i < 8; i++) begin
      lo[i*8 +: 8] = 8'h40;
      hi[i*8 +: 8] = 8'hc0;
      smp[i*8 +: 8] = i[0] ? 8'hc1 : 8'h3f;
    end
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    rdchk(err_status_pkg::ADDR_VOLT_FLAGS, err_status_pkg::FLAGS_RESET);
    rdchk(err_status_pkg::ADDR_FAULT_FLAGS, err_status_pkg::FLAGS_RESET);
    rdchk(8'h4c, err_status_pkg::UNMAPPED_DATA);
    $display("test reset done");
    rdchk(err_status_pkg::ADDR_VOLT_FLAGS, 8'h00);
    pulse_vld(8'h0f);
    rdchk(err_status_pkg::ADDR_VOLT_FLAGS, 8'h0f);
    // Samples equal to a limit lie inside the window
    for (int i = 4; i < 8; i++) smp[i*8 +: 8] = i[0] ? 8'hc0 : 8'h40;
    pulse_vld(8'hf0);
    rdchk(err_status_pkg::ADDR_VOLT_FLAGS, 8'h0f);
    for (int i = 4; i < 8; i++) smp[i*8 +: 8] = i[0] ? 8'hc1 : 8'h3f;
    pulse_vld(8'hf0);
    rdchk(err_status_pkg::ADDR_VOLT_FLAGS, 8'hff);
    u_host.wr(err_status_pkg::ADDR_VOLT_FLAGS, 8'h0f);
    rdchk(err_status_pkg::ADDR_VOLT_FLAGS, 8'hf0);
    u_host.wr(err_status_pkg::ADDR_VOLT_FLAGS, 8'hf0);
    rdchk(err_status_pkg::ADDR_VOLT_FLAGS, 8'h00);
    $display("test channels done");
    acc = 8'h00;
    for (int k = 0; k < 6; k++) begin
      @(negedge clk);
      flt = 6'h01 << k;
      @(negedge clk);
      flt = 6'h00;
      acc = acc | (8'h04 << k);
      rdchk(err_status_pkg::ADDR_FAULT_FLAGS, acc);
    end
    u_host.wr(err_status_pkg::ADDR_FAULT_FLAGS, 8'h03);
    rdchk(err_status_pkg::ADDR_FAULT_FLAGS, 8'hfc);
    // A source still high re-sets its flag through the clear
    flt = 6'h01;
    u_host.wr(err_status_pkg::ADDR_FAULT_FLAGS, 8'hfc);
    rdchk(err_status_pkg::ADDR_FAULT_FLAGS, 8'h04);
    flt = 6'h00;
    u_host.wr(err_status_pkg::ADDR_FAULT_FLAGS, 8'h04);
    rdchk(err_status_pkg::ADDR_FAULT_FLAGS, 8'h00);
    $display("test faults done");
    // Flags raised again are wiped by a reset in mid-run
    pulse_vld(8'hff);
    flt = 6'h3f;
    @(negedge clk);
    flt = 6'h00;
    rdchk(err_status_pkg::ADDR_VOLT_FLAGS, 8'hff);
    rdchk(err_status_pkg::ADDR_FAULT_FLAGS, 8'hfc);
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rdchk(err_status_pkg::ADDR_VOLT_FLAGS, err_status_pkg::FLAGS_RESET);
    rdchk(err_status_pkg::ADDR_FAULT_FLAGS, err_status_pkg::FLAGS_RESET);
    $display("test mid-run reset done");
    test_done();
  end
  // Watchdog well beyond the fewer than a hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    test_done();
  end
endmodule
